// *** logic/mfl_addr_match.sv ***
/*
  Target address filter: physical node address or one of the enabled functional addresses.
  Assumes its inputs are stable registered values; the result is purely combinational.
*/
`timescale 1ns/1ps
module mfl_addr_match import mfl_pkg::*; (
  input wire logic [7:0] tgt_i, // decoded target address
  input wire logic [7:0] phys_addr_i, // this node's physical address
  input wire logic [NUM_FUNC-1:0][7:0] func_addr_i, // functional addresses of interest
  input wire logic [NUM_FUNC-1:0] func_en_i, // per-entry enable
  output logic hit_o // frame is for this node
);

  logic [NUM_FUNC-1:0] fhit;

  ////////////////////////////////////////////////////////////////////////////////
  // one comparator per functional entry
  for (genvar i = 0; i < NUM_FUNC; i++) begin : g_func
    assign fhit[i] = func_en_i[i] && (func_addr_i[i] == tgt_i);
  end

  // direct and functional addressing share the same target byte
  assign hit_o = (tgt_i == phys_addr_i) || (|fhit);

endmodule : mfl_addr_match

// *** logic/mfl_crc8.sv ***
/*
  Bit-serial CRC register used for frame and in-frame response check bytes.
  Assumes the caller pulses shift_i once per bus bit and clr_i before each protected field.
*/
`timescale 1ns/1ps
module mfl_crc8 import mfl_pkg::*; (
  input wire logic ref_clk_i, // 40 MHz clock
  input wire logic nrst_i, // async reset, active low
  input wire logic clr_i, // preset the register
  input wire logic shift_i, // shift in bit_i
  input wire logic bit_i, // bus bit, msb first
  output logic [7:0] crc_o, // current remainder
  output logic [7:0] crc_next_o // remainder once bit_i is included
);

  typedef struct packed {
    logic [7:0] crc;
  } mfl_crc_t;

  mfl_crc_t s;
  mfl_crc_t next_s;
  logic fb;

  ////////////////////////////////////////////////////////////////////////////////
  // one polynomial step per bit; the look-ahead lets the sender append without a bubble
  always_comb begin
    fb = s.crc[7] ^ bit_i;
    crc_next_o = {s.crc[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
    next_s = s;
    if (clr_i) begin
      next_s.crc = CRC_INIT;
    end else if (shift_i) begin
      next_s.crc = crc_next_o;
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s.crc <= CRC_INIT;
    end else begin
      s <= next_s;
    end
  end

  assign crc_o = s.crc;

  property p_clr_init;
    @(posedge ref_clk_i) disable iff (!nrst_i) clr_i |=> (crc_o == CRC_INIT);
  endproperty
  a_clr_init: assert property (p_clr_init) else $error("crc not preset after clear");

endmodule : mfl_crc8

// *** logic/mfl_frame_link.sv ***
/*
  Frame link layer for a Class B shared multiplex bus node: framing, error byte, address
  filter, bitwise arbitration and in-frame response of the physical address.
  Assumes a symbol layer that sends the start delimiter on tx_req_o, reports every resolved
  bus bit with bit_stb_i, and reports delimiters as one-cycle pulses.
*/
// Summary of operation
// - delimiter, header, data, error byte, delimiters
// - single-byte header: variable pulse width at 10.4k, checksum
// - consolidated headers use CRC, either encoding
// - limit frame to 12 bytes or 101 bits
// - bytes travel most significant bit first
// - single-byte header holds priority and target
// - header bit 4 set: one-byte consolidated
// - header bit 4 clear: three header bytes
// - three-byte header: priority, target, source
// - accept frames for own physical address
// - accept enabled functional target addresses
// - checksum is byte sum of earlier bytes
// - transmitter appends CRC after data bytes
// - receiver checks CRC remainder equals C4
// - bad error byte: discard, no response
// - start transmitting only on a free bus
// - arbitrate every bit after start delimiter
// - zero dominates one, lowest value wins
// - on loss release bus, retry when idle
// - response holds one or more bytes
// - variable pulse width: normalization bit first
// - single response byte is physical address
// - response CRC checked like frame CRC
`timescale 1ns/1ps
module mfl_frame_link import mfl_pkg::*; (
  input wire logic ref_clk_i, // 40 MHz clock
  input wire logic nrst_i, // async reset, active low
  input wire logic vpw_mode_i, // 1: variable pulse width encoding, 0: pulse width
  input wire logic single_hdr_i, // 1: single-byte header format with checksum
  input wire logic [7:0] phys_addr_i, // physical node address
  input wire logic [NUM_FUNC-1:0][7:0] func_addr_i, // functional addresses
  input wire logic [NUM_FUNC-1:0] func_en_i, // functional address enables
  input wire logic ifr_en_i, // answer accepted frames with an in-frame response
  input wire logic tx_wr_i, // write tx_data_i into the send buffer
  input wire logic [7:0] tx_data_i, // header or data byte to send
  input wire logic tx_go_i, // queue the buffered frame
  input wire logic bus_idle_i, // bus is free
  input wire logic sof_i, // start delimiter seen
  input wire logic bit_stb_i, // one resolved bus bit
  input wire logic bit_val_i, // bus level of that bit, 0 dominant
  input wire logic eod_i, // data end delimiter seen
  input wire logic eof_i, // frame end delimiter seen
  output logic tx_req_o, // ask symbol layer for a start delimiter
  output logic tx_drive_o, // node drives the next bit
  output logic tx_bit_o, // bit to drive
  output logic tx_nb_o, // send normalization bit before the next bit
  output logic tx_busy_o, // a frame is queued
  output logic tx_done_o, // own frame sent, pulse
  output logic arb_lost_o, // arbitration lost, pulse
  output logic [7:0] rx_byte_o, // received byte
  output logic rx_byte_vld_o, // rx_byte_o valid, pulse
  output logic [7:0] rx_tgt_o, // target address of the last frame
  output logic [7:0] rx_src_o, // source address, three-byte headers only
  output logic rx_ok_o, // accepted error free frame, pulse
  output logic rx_bad_o, // error byte or framing failure, pulse
  output logic ifr_ok_o, // multi-byte response with good CRC, pulse
  output logic cfg_err_o // header format not allowed with this encoding
);

  mfl_top_t s;
  mfl_top_t next_s;
  logic [7:0] byte_w;
  logic [7:0] crc_q;
  logic [7:0] crc_nx;
  logic crc_clr;
  logic crc_sh;
  logic hit;
  logic err_ok;
  logic good;

  ////////////////////////////////////////////////////////////////////////////////
  // helpers
  mfl_crc8 u_crc (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .clr_i(crc_clr),
    .shift_i(crc_sh),
    .bit_i(bit_val_i),
    .crc_o(crc_q),
    .crc_next_o(crc_nx)
  );

  mfl_addr_match u_addr (
    .tgt_i(s.tgt),
    .phys_addr_i(phys_addr_i),
    .func_addr_i(func_addr_i),
    .func_en_i(func_en_i),
    .hit_o(hit)
  );

  // byte assembled msb first from the shift register and the current bus bit
  assign byte_w = {s.rxsh[6:0], bit_val_i};
  // single-byte header frames use the checksum, the others the CRC remainder
  assign err_ok = single_hdr_i ? (s.last == s.psum) : (crc_q == CRC_RESIDUE);
  assign good = err_ok && (s.rbit == 3'h0) && (s.rbytes > {2'h0, s.hlen}) && !s.lenerr;

  ////////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    next_s = s;
    crc_clr = 1'b0;
    crc_sh = 1'b0;
    next_s.done = 1'b0;
    next_s.lost = 1'b0;
    next_s.rxv = 1'b0;
    next_s.ok = 1'b0;
    next_s.bad = 1'b0;
    next_s.ifrok = 1'b0;
    // single-byte headers exist only under variable pulse width encoding
    next_s.cfgerr = single_hdr_i && !vpw_mode_i;

    // host side loading; the buffer is frozen while a frame is queued
    if (tx_wr_i && !s.pend && (s.wptr != TX_BUF_LAST)) begin
      next_s.buffer[s.wptr] = tx_data_i;
      next_s.wptr = 4'(s.wptr + 4'h1);
    end
    if (tx_go_i && !s.pend && (s.wptr != 4'h0) && !next_s.cfgerr) begin
      next_s.pend = 1'b1;
      next_s.txlen = s.wptr;
      next_s.wptr = 4'h0;
    end
    next_s.req = s.pend && (s.state == S_IDLE) && bus_idle_i && !next_s.cfgerr;

    // every bus bit inside a frame feeds the receive shifter and the CRC
    if (bit_stb_i && (s.state != S_IDLE)) begin
      crc_sh = 1'b1;
      next_s.rxsh = byte_w;
      next_s.rbit = 3'(s.rbit + 3'h1);
      if ((s.state != S_FRAME) && (s.rbit == 3'h7) && (s.ifrbytes != 4'hF)) begin
        next_s.ifrbytes = 4'(s.ifrbytes + 4'h1);
      end
    end

    unique case (s.state)
      S_IDLE: begin
        if (sof_i) begin
          next_s.state = S_FRAME;
          next_s.req = 1'b0;
          crc_clr = 1'b1;
          next_s.rbit = 3'h0;
          next_s.rbytes = 4'h0;
          next_s.bitsum = 7'h00;
          next_s.sum = 8'h00;
          next_s.psum = 8'h00;
          next_s.last = 8'h00;
          next_s.hlen = HDR_LEN_ONE;
          next_s.lenerr = 1'b0;
          next_s.mine = s.req;
          if (s.req) begin
            // first bit after the delimiter is already contested
            next_s.drive = 1'b1;
            next_s.txsh = s.buffer[0];
            next_s.txidx = 4'h1;
            next_s.tbit = 3'h0;
            next_s.txerr = 1'b0;
          end
        end
      end
      S_FRAME: begin
        if (bit_stb_i) begin
          if (s.bitsum != 7'h7F) begin
            next_s.bitsum = 7'(s.bitsum + 7'h01);
          end
          if (s.rbit == 3'h7) begin
            next_s.rxb = byte_w;
            next_s.rxv = 1'b1;
            next_s.psum = s.sum;
            next_s.sum = 8'(s.sum + byte_w);
            next_s.last = byte_w;
            if (s.rbytes != 4'hF) begin
              next_s.rbytes = 4'(s.rbytes + 4'h1);
            end
            if (s.rbytes == 4'h0) begin
              // first byte decides the header length
              next_s.hlen = (single_hdr_i || byte_w[HDR_FMT_BIT]) ? HDR_LEN_ONE : HDR_LEN_THREE;
              next_s.tgt = byte_w;
            end
            if ((s.rbytes == 4'h1) && (s.hlen == HDR_LEN_THREE)) begin
              next_s.tgt = byte_w;
            end
            if ((s.rbytes == 4'h2) && (s.hlen == HDR_LEN_THREE)) begin
              next_s.src = byte_w;
            end
            if (vpw_mode_i ? (next_s.bitsum > VPW_MAX_BIT_TIMES) : (s.rbytes >= PWM_MAX_FRAME_BYTES)) begin
              next_s.lenerr = 1'b1;
            end
            if (s.rbytes >= 4'({2'h0, s.hlen} + MAX_DATA_PLUS_ERR)) begin
              next_s.lenerr = 1'b1;
            end
          end
          if (s.drive) begin
            if (s.txsh[7] && !bit_val_i) begin
              // a dominant zero overrode our one: release at this bit boundary
              next_s.drive = 1'b0;
              next_s.mine = 1'b0;
              next_s.lost = 1'b1;
            end else begin
              next_s.txsh = {s.txsh[6:0], 1'b0};
              next_s.tbit = 3'(s.tbit + 3'h1);
              if (s.tbit == 3'h7) begin
                if (s.txidx < s.txlen) begin
                  next_s.txsh = s.buffer[s.txidx];
                  next_s.txidx = 4'(s.txidx + 4'h1);
                end else if (!s.txerr) begin
                  // error byte right after the data, no gap bit
                  next_s.txerr = 1'b1;
                  next_s.txsh = single_hdr_i ? 8'(s.sum + byte_w) : ~crc_nx;
                end else begin
                  next_s.drive = 1'b0;
                end
              end
            end
          end
        end
        if (eod_i) begin
          next_s.drive = 1'b0;
          next_s.rbit = 3'h0;
          next_s.ifrbytes = 4'h0;
          crc_clr = 1'b1;
          next_s.state = S_RESP;
          if (s.mine) begin
            next_s.done = 1'b1;
            next_s.pend = 1'b0;
            next_s.mine = 1'b0;
          end else if (!good) begin
            next_s.bad = 1'b1;
          end else if (hit) begin
            next_s.ok = 1'b1;
            if (ifr_en_i) begin
              next_s.state = S_IFR_TX;
              next_s.drive = 1'b1;
              next_s.nb = vpw_mode_i;
              next_s.txsh = phys_addr_i;
              next_s.tbit = 3'h0;
            end
          end
        end
      end
      S_IFR_TX: begin
        if (bit_stb_i) begin
          next_s.nb = 1'b0;
          if (s.txsh[7] && !bit_val_i) begin
            // another responder with a lower identification byte goes on alone
            next_s.drive = 1'b0;
            next_s.state = S_RESP;
          end else begin
            next_s.txsh = {s.txsh[6:0], 1'b0};
            next_s.tbit = 3'(s.tbit + 3'h1);
            if (s.tbit == 3'h7) begin
              next_s.drive = 1'b0;
              next_s.state = S_RESP;
            end
          end
        end
      end
      S_RESP: begin
        // response bytes of other nodes only update the CRC and the byte count
      end
    endcase

    // frame end closes everything; a frame of another node cut short of its data end is a failure
    if (eof_i && (s.state != S_IDLE)) begin
      next_s.state = S_IDLE;
      next_s.drive = 1'b0;
      next_s.nb = 1'b0;
      next_s.mine = 1'b0;
      if ((s.state == S_FRAME) && !s.mine) begin
        next_s.bad = 1'b1;
      end
      if ((s.state != S_FRAME) && (s.ifrbytes > 4'h1) && (s.rbit == 3'h0) && (crc_q == CRC_RESIDUE)) begin
        next_s.ifrok = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s <= TOP_RESET;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from the state register
  assign tx_req_o = s.req;
  assign tx_drive_o = s.drive;
  assign tx_bit_o = s.txsh[7];
  assign tx_nb_o = s.nb;
  assign tx_busy_o = s.pend;
  assign tx_done_o = s.done;
  assign arb_lost_o = s.lost;
  assign rx_byte_o = s.rxb;
  assign rx_byte_vld_o = s.rxv;
  assign rx_tgt_o = s.tgt;
  assign rx_src_o = s.src;
  assign rx_ok_o = s.ok;
  assign rx_bad_o = s.bad;
  assign ifr_ok_o = s.ifrok;
  assign cfg_err_o = s.cfgerr;

  ////////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!nrst_i);

  property p_lost_release;
    (s.state == S_FRAME && bit_stb_i && s.drive && s.txsh[7] && !bit_val_i) |=> (!tx_drive_o && arb_lost_o);
  endproperty
  a_lost_release: assert property (p_lost_release) else $error("bus not released after arbitration loss");

  property p_req_idle;
    tx_req_o |-> ($past(bus_idle_i) && $past(s.pend));
  endproperty
  a_req_idle: assert property (p_req_idle) else $error("start requested on a busy bus");

  property p_arb_start;
    (s.state == S_IDLE && sof_i && tx_req_o) |=> (tx_drive_o && s.mine && s.txidx == 4'h1);
  endproperty
  a_arb_start: assert property (p_arb_start) else $error("first bit after start not driven");

  property p_msb_first;
    rx_byte_vld_o |-> (rx_byte_o[0] == $past(bit_val_i) && rx_byte_o[7] == $past(s.rxsh[6]));
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("received byte not msb first");

  property p_bad_quiet;
    rx_bad_o |-> (!tx_drive_o && s.state != S_IFR_TX);
  endproperty
  a_bad_quiet: assert property (p_bad_quiet) else $error("response after failed error byte");

  property p_cfg_block;
    (single_hdr_i && !vpw_mode_i) |=> (!tx_req_o && cfg_err_o);
  endproperty
  a_cfg_block: assert property (p_cfg_block) else $error("bad format with encoding not refused");

  property p_ifr_id;
    $rose(s.state == S_IFR_TX) |-> (tx_drive_o && s.txsh == $past(phys_addr_i) && rx_ok_o);
  endproperty
  a_ifr_id: assert property (p_ifr_id) else $error("response byte is not the physical address");

  property p_nb_vpw;
    $rose(s.state == S_IFR_TX) |-> (tx_nb_o == $past(vpw_mode_i));
  endproperty
  a_nb_vpw: assert property (p_nb_vpw) else $error("normalization bit request wrong");

  property p_crc_residue;
    (rx_ok_o && !$past(single_hdr_i)) |-> ($past(crc_q) == CRC_RESIDUE);
  endproperty
  a_crc_residue: assert property (p_crc_residue) else $error("frame accepted without C4 remainder");

  property p_checksum;
    (rx_ok_o && $past(single_hdr_i)) |-> ($past(s.last) == $past(s.psum));
  endproperty
  a_checksum: assert property (p_checksum) else $error("frame accepted with wrong checksum");

  c_arb_lost: cover property (arb_lost_o);
  c_rx_ok: cover property (rx_ok_o);
  c_ifr_sent: cover property ($fell(s.state == S_IFR_TX));
  c_tx_done: cover property (tx_done_o);

endmodule : mfl_frame_link

// *** logic/mfl_pkg.sv ***
/*
  Constants and types shared by the multiplex frame link block.
  Assumes a bit-level symbol layer outside the block that handles pulse timing and delimiters.
*/
package mfl_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // error detection
  localparam logic [7:0] CRC_POLY = 8'h1D; // shift register feedback taps
  localparam logic [7:0] CRC_INIT = 8'hFF; // preset before the first header bit
  localparam logic [7:0] CRC_RESIDUE = 8'hC4; // remainder of an error free frame

  ////////////////////////////////////////////////////////////////////////////////
  // frame geometry
  localparam int unsigned TX_BUF_BYTES = 11; // three header bytes plus eight data bytes
  localparam logic [3:0] TX_BUF_LAST = 4'hB; // write pointer value when the buffer is full
  localparam logic [3:0] PWM_MAX_FRAME_BYTES = 4'hC; // twelve bytes
  localparam logic [6:0] VPW_MAX_BIT_TIMES = 7'h65; // 101 bit times
  localparam logic [3:0] MAX_DATA_PLUS_ERR = 4'h9; // eight data bytes plus the error byte
  localparam int unsigned HDR_FMT_BIT = 4; // set: one-byte consolidated header
  localparam logic [1:0] HDR_LEN_ONE = 2'h1;
  localparam logic [1:0] HDR_LEN_THREE = 2'h3;
  localparam int unsigned NUM_FUNC = 4; // functional addresses the node listens to

  ////////////////////////////////////////////////////////////////////////////////
  // top level state
  typedef enum logic [1:0] {S_IDLE, S_FRAME, S_IFR_TX, S_RESP} mfl_state_t;

  typedef struct packed {
    mfl_state_t state;
    logic [TX_BUF_BYTES-1:0][7:0] buffer;
    logic [3:0] wptr;
    logic [3:0] txlen;
    logic [3:0] txidx;
    logic [2:0] tbit;
    logic [7:0] txsh;
    logic txerr;
    logic mine;
    logic pend;
    logic drive;
    logic req;
    logic nb;
    logic done;
    logic lost;
    logic [7:0] rxsh;
    logic [2:0] rbit;
    logic [3:0] rbytes;
    logic [6:0] bitsum;
    logic [7:0] sum;
    logic [7:0] psum;
    logic [7:0] last;
    logic [1:0] hlen;
    logic [7:0] tgt;
    logic [7:0] src;
    logic lenerr;
    logic [7:0] rxb;
    logic rxv;
    logic ok;
    logic bad;
    logic ifrok;
    logic cfgerr;
    logic [3:0] ifrbytes;
  } mfl_top_t;

  localparam mfl_top_t TOP_RESET = '0; // idle, nothing pending, bus released

endpackage : mfl_pkg

// *** tb/mfl_peer_node.sv ***
/*
  Peer node and symbol layer model: sends frames, resolves each bus bit, records what the bus carried.
  Assumes the bench calls frame() and reads seen after it returns; one clock shared with the block.
*/
`timescale 1ns/1ps
module mfl_peer_node (
  input wire logic ref_clk_i, // bench clock
  input wire logic tx_req_i, // block asks for a start delimiter
  input wire logic tx_drive_i, // block drives the next slot
  input wire logic tx_bit_i, // block bit for the next slot
  output logic bus_idle_o, // bus free
  output logic sof_o, // start delimiter pulse
  output logic bit_stb_o, // resolved bit pulse
  output logic bit_val_o, // resolved bus level
  output logic eod_o, // data end delimiter pulse
  output logic eof_o // frame end delimiter pulse
);
  logic seen [$];

  ////////////////////////////////////////////////////////////////////////////////
  // quiet bus at time zero
  initial begin
    bus_idle_o = 1'b1;
    sof_o = 1'b0;
    bit_stb_o = 1'b0;
    bit_val_o = 1'b1;
    eod_o = 1'b0;
    eof_o = 1'b0;
  end

  task automatic tick;
    @(posedge ref_clk_i);
    #1;
  endtask : tick

  // three cycles a slot so the block's next bit has settled before it is resolved
  task automatic slot(input logic b);
    tick();
    tick();
    bit_val_o = b & (tx_drive_i ? tx_bit_i : 1'b1);
    bit_stb_o = 1'b1;
    seen.push_back(bit_val_o);
    tick();
    bit_stb_o = 1'b0;
    bit_val_o = ~bit_val_o; // inverted level between strobes, no stale level
  endtask : slot

  // one whole frame; the peer header decides arbitration before its end
  task automatic frame(input logic [7:0] q [$], input logic [7:0] r [$], input bit wreq);
    int n;
    n = 0;
    seen.delete();
    while (wreq && !tx_req_i && n < 2000) begin
      tick();
      n++;
    end
    tick();
    bus_idle_o = 1'b0;
    sof_o = 1'b1;
    tick();
    sof_o = 1'b0;
    foreach (q[i]) for (int k = 7; k >= 0; k--) slot(q[i][k]);
    tick();
    eod_o = 1'b1;
    tick();
    eod_o = 1'b0;
    foreach (r[i]) for (int k = 7; k >= 0; k--) slot(r[i][k]);
    tick();
    eof_o = 1'b1;
    tick();
    eof_o = 1'b0;
    bus_idle_o = 1'b1;
  endtask : frame
endmodule : mfl_peer_node

// *** tb/testbench.sv ***
/*
  Self-checking bench for the frame link block, scenario tasks run in sequence.
  Assumes mfl_peer_node stands in for the symbol layer and all other nodes.
*/
`timescale 1ns/1ps
module testbench import mfl_pkg::*;;
  logic ref_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic variable_pulse_width_encoding = 1'b0, sh = 1'b0, ifr_en = 1'b0, tx_wr = 1'b0, tx_go = 1'b0;
  logic [7:0] tx_data = 8'h00, phys = 8'h2C;
  logic [NUM_FUNC-1:0][7:0] faddr = {8'h00, 8'hA6, 8'h00, 8'h00};
  logic [NUM_FUNC-1:0] fen = 4'h4;
  logic idle, sof, stb, val, data_end_delimiter, eof, req, drv, tbit, nb, busy, done, lost;
  logic rx_vld, rx_ok, rx_bad, ifr_ok, cfg_err;
  logic [7:0] rx_byte, rx_tgt, rx_src;
  int err_total = 0, checked = 0, n_ok = 0, n_bad = 0, n_lost = 0, n_done = 0, n_nb = 0, n_ifr = 0, n_vld = 0;
  logic [7:0] no_resp [$]; // stays empty: frames without a response

  always #12.5 ref_clk_i = ~ref_clk_i;

  mfl_frame_link u_mfl_frame_link (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .vpw_mode_i(variable_pulse_width_encoding),
    .single_hdr_i(sh), .phys_addr_i(phys), .func_addr_i(faddr), .func_en_i(fen), .ifr_en_i(ifr_en),
    .tx_wr_i(tx_wr), .tx_data_i(tx_data), .tx_go_i(tx_go), .bus_idle_i(idle), .sof_i(sof),
    .bit_stb_i(stb), .bit_val_i(val), .eod_i(data_end_delimiter), .eof_i(eof), .tx_req_o(req), .tx_drive_o(drv),
    .tx_bit_o(tbit), .tx_nb_o(nb), .tx_busy_o(busy), .tx_done_o(done), .arb_lost_o(lost),
    .rx_byte_o(rx_byte), .rx_byte_vld_o(rx_vld), .rx_tgt_o(rx_tgt), .rx_src_o(rx_src),
    .rx_ok_o(rx_ok), .rx_bad_o(rx_bad), .ifr_ok_o(ifr_ok), .cfg_err_o(cfg_err));

  mfl_peer_node u_peer (.ref_clk_i(ref_clk_i), .tx_req_i(req), .tx_drive_i(drv), .tx_bit_i(tbit),
    .bus_idle_o(idle), .sof_o(sof), .bit_stb_o(stb), .bit_val_o(val), .eod_o(data_end_delimiter), .eof_o(eof));

  ////////////////////////////////////////////////////////////////////////////////
  // pulse counters, so no one-cycle event slips past a scenario
  always @(posedge ref_clk_i) begin
    if (rx_ok === 1'b1) n_ok++;
    if (rx_bad === 1'b1) n_bad++;
    if (lost === 1'b1) n_lost++;
    if (done === 1'b1) n_done++;
    if (nb === 1'b1) n_nb++;
    if (ifr_ok === 1'b1) n_ifr++;
    if (rx_vld === 1'b1) n_vld++;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // helpers
  task automatic check(input string nm, input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : check

  task automatic give_verdict;
    $display("checked %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : give_verdict

  task automatic tick;
    @(posedge ref_clk_i);
    #1;
  endtask : tick

  task automatic wr(input logic [7:0] d);
    tick();
    tx_wr = 1'b1;
    tx_data = d;
    tick();
    tx_wr = 1'b0;
  endtask : wr

  // crc preset to all ones, msb first, sent inverted
  function automatic logic [7:0] crc8(input logic [7:0] q [$]);
    logic [7:0] c;
    c = CRC_INIT;
    foreach (q[i]) for (int k = 7; k >= 0; k--) c = {c[6:0], 1'b0} ^ ((c[7] ^ q[i][k]) ? CRC_POLY : 8'h00);
    return ~c;
  endfunction : crc8

  function automatic logic [7:0] byte_at(input int i);
    logic [7:0] b;
    for (int k = 0; k < 8; k++) b = {b[6:0], u_peer.seen[8 * i + k]};
    return b;
  endfunction : byte_at

  ////////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_tx_arb;
    logic [7:0] q [$];
    logic [7:0] e [$];
    int b;
    e = '{8'h18, 8'h55};
    foreach (e[i]) wr(e[i]);
    tick();
    tx_go = 1'b1;
    tick();
    tx_go = 1'b0;
    tick();
    check("busy", {7'h0, busy}, 8'h01);
    q = '{8'h08, 8'h40, 8'h20};
    q.push_back(crc8(q));
    b = n_lost;
    u_peer.frame(q, no_resp, 1'b1);
    repeat (4) tick();
    check("lost", 8'(n_lost - b), 8'h01);
    foreach (q[i]) check("winner byte", byte_at(i), q[i]);
    check("busy held", {7'h0, busy}, 8'h01);
    e.push_back(crc8(e));
    b = n_done;
    u_peer.frame('{8'hFF, 8'hFF, 8'hFF}, no_resp, 1'b1);
    repeat (4) tick();
    foreach (e[i]) check("sent byte", byte_at(i), e[i]);
    check("done", 8'(n_done - b), 8'h01);
    check("busy end", {7'h0, busy}, 8'h00);
  endtask : t_tx_arb

  // each case: frame bytes, good or bad error byte, response bytes of another node
  task automatic t_rx(input logic [7:0] h [$], input bit good, input int ndata, input logic [7:0] r [$],
      input logic [7:0] tgt, input logic [7:0] ok_d, input logic [7:0] bad_d, input logic [7:0] ifr_d);
    logic [7:0] q [$];
    logic [7:0] cs;
    int o, bd, f, v;
    q = h;
    repeat (ndata) q.push_back(8'h42);
    cs = 8'h00;
    foreach (q[i]) cs = cs + q[i];
    if (sh) q.push_back(cs);
    else q.push_back(good ? crc8(q) : ~crc8(q));
    o = n_ok;
    bd = n_bad;
    f = n_ifr;
    v = n_vld;
    u_peer.frame(q, r, 1'b0);
    repeat (4) tick();
    check("ok count", 8'(n_ok - o), ok_d);
    check("bad count", 8'(n_bad - bd), bad_d);
    check("target", rx_tgt, tgt);
    check("last byte", rx_byte, q[q.size() - 1]);
    check("byte count", 8'(n_vld - v), 8'(q.size()));
    check("ifr ok", 8'(n_ifr - f), ifr_d);
  endtask : t_rx

  task automatic t_cfg;
    sh = 1'b1;
    variable_pulse_width_encoding = 1'b0;
    repeat (3) tick();
    check("cfg err", {7'h0, cfg_err}, 8'h01);
    variable_pulse_width_encoding = 1'b1;
    repeat (3) tick();
    check("cfg ok", {7'h0, cfg_err}, 8'h00);
  endtask : t_cfg

  // own physical address, three-byte header; the block answers with its address
  task automatic t_phys_ifr;
    ifr_en = 1'b1;
    variable_pulse_width_encoding = 1'b1;
    t_rx('{8'h68, 8'h2C, 8'h10}, 1'b1, 1, '{8'hFF}, 8'h2C, 8'h01, 8'h00, 8'h00);
    check("response id", byte_at(5), phys);
    check("source", rx_src, 8'h10);
    check("norm bit", {7'h0, n_nb > 0}, 8'h01);
  endtask : t_phys_ifr

  // corrupted CRC: discarded and no response even with responses enabled
  task automatic t_bad_crc;
    variable_pulse_width_encoding = 1'b0;
    t_rx('{8'h68, 8'h2C, 8'h10}, 1'b0, 1, '{8'hFF}, 8'h2C, 8'h00, 8'h01, 8'h00);
    check("no response", byte_at(5), 8'hFF);
    ifr_en = 1'b0;
  endtask : t_bad_crc

  // too long a frame, then a frame for another node
  task automatic t_no_accept;
    t_rx('{8'h68, 8'h2C, 8'h10}, 1'b1, 9, no_resp, 8'h2C, 8'h00, 8'h01, 8'h00);
    t_rx('{8'h18}, 1'b1, 2, no_resp, 8'h18, 8'h00, 8'h00, 8'h00);
  endtask : t_no_accept

  // own single-byte header frame ends in the plain byte sum
  task automatic t_tx_sum;
    logic [7:0] e [$];
    int d;
    e = '{8'h48, 8'h11, 8'h59};
    wr(e[0]);
    wr(e[1]);
    tick();
    tx_go = 1'b1;
    tick();
    tx_go = 1'b0;
    d = n_done;
    u_peer.frame('{8'hFF, 8'hFF, 8'hFF}, no_resp, 1'b1);
    repeat (4) tick();
    foreach (e[i]) check("sum frame byte", byte_at(i), e[i]);
    check("sum done", 8'(n_done - d), 8'h01);
  endtask : t_tx_sum

  // functional target with checksum; another node answers with data and its CRC
  task automatic t_func_sum;
    t_rx('{8'hA6}, 1'b1, 2, '{8'h5A, crc8('{8'h5A})}, 8'hA6, 8'h01, 8'h00, 8'h01);
  endtask : t_func_sum

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence and watchdog
  initial begin
    repeat (10) @(posedge ref_clk_i);
    #1;
    nrst_i = 1'b1;
    tick();
    t_tx_arb();
    t_phys_ifr();
    t_bad_crc();
    t_no_accept();
    t_cfg();
    t_tx_sum();
    t_func_sum();
    give_verdict();
  end

  initial begin
    repeat (40000) @(posedge ref_clk_i);
    err_total++;
    give_verdict();
  end
endmodule : testbench
